// ---- ums_cfg.svh ----
`ifndef UMS_CFG_SVH
`define UMS_CFG_SVH

// ****************************************
// register byte addresses
// ****************************************
`define UMS_ADDR_STATUS     32'h50001118
`define UMS_ADDR_CONTROL    32'h50001110
`define UMS_ADDR_IRQ_STAT   32'h50001200
`define UMS_ADDR_IRQ_MASK   32'h50001204

// ****************************************
// modem line status fields
// ****************************************
`define UMS_ST_CD_BIT       7
`define UMS_ST_RI_BIT       6
`define UMS_ST_CTS_BIT      4
`define UMS_ST_DCD_BIT      3
`define UMS_ST_TERI_BIT     2
`define UMS_ST_DCTS_BIT     0
`define UMS_ST_WIDTH        16

// ****************************************
// modem line control fields
// ****************************************
`define UMS_CT_LOOP_BIT     4
`define UMS_CT_USER_OUTPUT_TWO_BIT     3
`define UMS_CT_USER_OUTPUT_ONE_BIT     2
`define UMS_CT_RTS_BIT      1
`define UMS_CT_DTR_BIT      0
`define UMS_CT_WIDTH        5

// ****************************************
// interrupt fields and reset values
// ****************************************
`define UMS_IRQ_CD_BIT      0
`define UMS_IRQ_RI_BIT      1
`define UMS_IRQ_CTS_BIT     2
`define UMS_IRQ_WIDTH       3
`define UMS_RST_STATUS      16'h0000
`define UMS_RST_CONTROL     5'h00
`define UMS_RST_IRQ_MASK    3'h0

`endif

// ---- ums_pkg.sv ----
package ums_pkg;

    // active-low modem inputs as they arrive on the pins
    typedef struct packed {
        logic carrierDetectInLow;
        logic ringIndicatorInLow;
        logic clearToSendInLow;
    } ums_modem_in_type;

    // modem control outputs, active low on the pins
    typedef struct packed {
        logic requestToSendOutLow;
        logic dataTerminalReadyOutLow;
        logic userOutputOneLow;
        logic userOutputTwoLow;
    } ums_modem_out_type;

    typedef enum logic [2:0] {
        REG_NONE,
        REG_STATUS,
        REG_CONTROL,
        REG_IRQ_STAT,
        REG_IRQ_MASK
    } ums_reg_type;

    typedef enum logic {
        APB_IDLE,
        APB_ANSWER
    } ums_apb_state_type;

endpackage

// ---- ums_change_detect.sv ----
module ums_change_detect #(
    parameter bit FALL_ONLY = 1'b0
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic clkEn,
    input  wire logic level,
    input  wire logic readClear,
    output logic      flag
);
    logic prev_r;
    logic hit;

    // prev starts deasserted, so a line held asserted through reset
    // is seen as a change right after release unless FALL_ONLY is set
    assign hit = FALL_ONLY ? (prev_r & ~level) : (prev_r ^ level);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prev_r <= 1'b0;
        end else if (clkEn) begin
            prev_r <= level;
        end
    end

    // set wins over a read that clears in the same cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            flag <= 1'b0;
        end else if (clkEn) begin
            flag <= hit | (flag & ~readClear);
        end
    end
endmodule

// ---- ums_irq_bank.sv ----
`include "ums_cfg.svh"
module ums_irq_bank #(
    parameter int WIDTH = 3
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             clkEn,
    input  wire logic [WIDTH-1:0] events,
    input  wire logic             clearWrite,
    input  wire logic             maskWrite,
    input  wire logic [WIDTH-1:0] wdata,
    output logic      [WIDTH-1:0] status,
    output logic      [WIDTH-1:0] mask,
    output logic                  irq
);
    logic [WIDTH-1:0] clearBits;

    assign clearBits = clearWrite ? wdata : '0;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            status <= '0;
        end else if (clkEn) begin
            status <= events | (status & ~clearBits);
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mask <= WIDTH'(`UMS_RST_IRQ_MASK);
        end else if (clkEn && maskWrite) begin
            mask <= wdata;
        end
    end

    // one cycle behind status, so irq stays a clean flop output
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else if (clkEn) begin
            irq <= |(status & mask);
        end
    end
endmodule

// ---- ums_modem_status.sv ----
// Operation
// RULE1: bit 7 reads inverted carrier detect input
// RULE2: bit 6 reads inverted ring indicator input
// RULE3: bit 4 reads inverted clear-to-send input
// RULE4: loopback: carrier bit follows user output two
// RULE5: loopback: ring bit follows user output one
// RULE6: loopback: clear-to-send bit follows request-to-send
// RULE7: bit 3 flags carrier change; read clears
// RULE8: loopback: carrier change tracks user output two
// RULE9: carrier held asserted through reset sets flag
// RULE10: bit 2 flags ring trailing edge; read clears
// RULE11: loopback: ring flag on output one falling
// RULE12: bit 0 flags clear-to-send change; read clears
// RULE13: loopback: clear-to-send change tracks request-to-send
// RULE14: clear-to-send held through reset sets flag
// RULE15: reserved bits zero; status writes ignored
`include "ums_cfg.svh"
module ums_modem_status #(
    parameter int ADDR_W = 32
) (
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    input  wire logic                     clkEn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [ADDR_W-1:0]        paddr,
    input  wire logic [31:0]              pwdata,
    input  wire logic [3:0]               pstrb,
    output logic                          pready,
    output logic [31:0]                   prdata,
    output logic                          pslverr,
    input  wire ums_pkg::ums_modem_in_type  modemIn,
    output ums_pkg::ums_modem_out_type      modemOut,
    output logic                          irq
);

    // ****************************************
    // address decode
    // ****************************************
    function automatic ums_pkg::ums_reg_type regSel(
        input logic [ADDR_W-1:0] addr
    );
        logic [31:0] a;
        a = 32'(addr);
        case (a)
            `UMS_ADDR_STATUS:   regSel = ums_pkg::REG_STATUS;
            `UMS_ADDR_CONTROL:  regSel = ums_pkg::REG_CONTROL;
            `UMS_ADDR_IRQ_STAT: regSel = ums_pkg::REG_IRQ_STAT;
            `UMS_ADDR_IRQ_MASK: regSel = ums_pkg::REG_IRQ_MASK;
            default:            regSel = ums_pkg::REG_NONE;
        endcase
    endfunction

    // ****************************************
    // declarations
    // ****************************************
    ums_pkg::ums_apb_state_type apbState_r;
    ums_pkg::ums_reg_type       sel;
    ums_pkg::ums_reg_type       heldSel_r;

    logic [`UMS_CT_WIDTH-1:0]  control_r;
    logic                      loopback;
    logic                      cdState;
    logic                      riState;
    logic                      ctsState;
    logic                      cdChanged;
    logic                      riTrailSeen;
    logic                      ctsChanged;
    logic [`UMS_ST_WIDTH-1:0]  statusWord;
    logic [`UMS_ST_WIDTH-1:0]  readSnap_r;
    logic                      setupPhase;
    logic                      accessDone;
    logic                      readDone;
    logic                      writeDone;
    logic                      statusRead;
    logic                      clrCd;
    logic                      clrRi;
    logic                      clrCts;
    logic [`UMS_IRQ_WIDTH-1:0] irqEvents;
    logic [`UMS_IRQ_WIDTH-1:0] irqStatus;
    logic [`UMS_IRQ_WIDTH-1:0] irqMask;
    logic                      irqClearWr;
    logic                      irqMaskWr;
    logic                      ctrlWr;
    logic [31:0]               readValue;

    // ****************************************
    // apb phase tracking
    // ****************************************
    assign sel        = regSel(paddr);
    assign setupPhase = psel && !penable && (apbState_r == ums_pkg::APB_IDLE);
    assign accessDone = psel && penable && pready;
    assign readDone   = accessDone && !pwrite;
    assign writeDone  = accessDone && pwrite;

    // every access answers one cycle after its setup cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            apbState_r <= ums_pkg::APB_IDLE;
        end else if (clkEn) begin
            case (apbState_r)
                ums_pkg::APB_IDLE: begin
                    if (setupPhase) begin
                        apbState_r <= ums_pkg::APB_ANSWER;
                    end
                end
                ums_pkg::APB_ANSWER: begin
                    apbState_r <= ums_pkg::APB_IDLE;
                end
                default: begin
                    apbState_r <= ums_pkg::APB_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pready <= 1'b0;
        end else if (clkEn) begin
            pready <= setupPhase;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            heldSel_r <= ums_pkg::REG_NONE;
        end else if (clkEn && setupPhase) begin
            heldSel_r <= sel;
        end
    end

    // unmapped addresses answer with an error, both directions
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pslverr <= 1'b0;
        end else if (clkEn) begin
            pslverr <= setupPhase && (sel == ums_pkg::REG_NONE);
        end
    end

    // ****************************************
    // modem line control register
    // ****************************************
    assign ctrlWr = writeDone && (heldSel_r == ums_pkg::REG_CONTROL)
                    && pstrb[0];

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            control_r <= `UMS_RST_CONTROL;
        end else if (clkEn && ctrlWr) begin
            control_r <= pwdata[`UMS_CT_WIDTH-1:0];
        end
    end

    assign loopback = control_r[`UMS_CT_LOOP_BIT];

    // ****************************************
    // line state, pins or loopback
    // ****************************************
    // the pins are complemented; loopback bits are already active high
    assign cdState  = loopback ? control_r[`UMS_CT_USER_OUTPUT_TWO_BIT]       // [RULE4]
                               : ~modemIn.carrierDetectInLow;      // [RULE1]
    assign riState  = loopback ? control_r[`UMS_CT_USER_OUTPUT_ONE_BIT]       // [RULE5]
                               : ~modemIn.ringIndicatorInLow;      // [RULE2]
    assign ctsState = loopback ? control_r[`UMS_CT_RTS_BIT]        // [RULE6]
                               : ~modemIn.clearToSendInLow;        // [RULE3]

    // ****************************************
    // change flags
    // ****************************************
    // a read clears only the flags that the read actually returned,
    // so an edge landing between setup and access is never lost
    assign statusRead = readDone && (heldSel_r == ums_pkg::REG_STATUS);
    assign clrCd  = statusRead && readSnap_r[`UMS_ST_DCD_BIT];
    assign clrRi  = statusRead && readSnap_r[`UMS_ST_TERI_BIT];
    assign clrCts = statusRead && readSnap_r[`UMS_ST_DCTS_BIT];

    // carrier change, sourced from the loopback mux
    ums_change_detect #(
        .FALL_ONLY (1'b0)
    ) cdDetect (
        .clk       (clk),
        .reset_n   (reset_n),
        .clkEn     (clkEn),
        .level     (cdState),   // [RULE8] [RULE9]
        .readClear (clrCd),     // [RULE7]
        .flag      (cdChanged)
    );

    // ring trailing edge: asserted to deasserted only
    ums_change_detect #(
        .FALL_ONLY (1'b1)
    ) riDetect (
        .clk       (clk),
        .reset_n   (reset_n),
        .clkEn     (clkEn),
        .level     (riState),   // [RULE11]
        .readClear (clrRi),     // [RULE10]
        .flag      (riTrailSeen)
    );

    ums_change_detect #(
        .FALL_ONLY (1'b0)
    ) ctsDetect (
        .clk       (clk),
        .reset_n   (reset_n),
        .clkEn     (clkEn),
        .level     (ctsState),  // [RULE13] [RULE14]
        .readClear (clrCts),    // [RULE12]
        .flag      (ctsChanged)
    );

    // ****************************************
    // modem line status word
    // ****************************************
    always_comb begin
        statusWord                   = `UMS_RST_STATUS;  // [RULE15]
        statusWord[`UMS_ST_CD_BIT]   = cdState;     // [RULE1]
        statusWord[`UMS_ST_RI_BIT]   = riState;     // [RULE2]
        statusWord[`UMS_ST_CTS_BIT]  = ctsState;    // [RULE3]
        statusWord[`UMS_ST_DCD_BIT]  = cdChanged;   // [RULE7]
        statusWord[`UMS_ST_TERI_BIT] = riTrailSeen; // [RULE10]
        statusWord[`UMS_ST_DCTS_BIT] = ctsChanged;  // [RULE12]
    end

    // ****************************************
    // interrupt status and mask
    // ****************************************
    assign irqEvents[`UMS_IRQ_CD_BIT]  = cdChanged;
    assign irqEvents[`UMS_IRQ_RI_BIT]  = riTrailSeen;
    assign irqEvents[`UMS_IRQ_CTS_BIT] = ctsChanged;
    assign irqClearWr = writeDone && (heldSel_r == ums_pkg::REG_IRQ_STAT)
                        && pstrb[0];
    assign irqMaskWr  = writeDone && (heldSel_r == ums_pkg::REG_IRQ_MASK)
                        && pstrb[0];

    // events are the flag levels, so a held flag keeps re-setting
    // its sticky bit until the status register is read
    ums_irq_bank #(
        .WIDTH (`UMS_IRQ_WIDTH)
    ) irqBank (
        .clk        (clk),
        .reset_n    (reset_n),
        .clkEn      (clkEn),
        .events     (irqEvents),
        .clearWrite (irqClearWr),
        .maskWrite  (irqMaskWr),
        .wdata      (pwdata[`UMS_IRQ_WIDTH-1:0]),
        .status     (irqStatus),
        .mask       (irqMask),
        .irq        (irq)
    );

    // ****************************************
    // read data
    // ****************************************
    always_comb begin
        readValue = 32'h00000000;
        case (sel)
            ums_pkg::REG_STATUS: begin
                readValue = 32'(statusWord);  // [RULE15]
            end
            ums_pkg::REG_CONTROL: begin
                readValue = 32'(control_r);
            end
            ums_pkg::REG_IRQ_STAT: begin
                readValue = 32'(irqStatus);
            end
            ums_pkg::REG_IRQ_MASK: begin
                readValue = 32'(irqMask);
            end
            default: begin
                readValue = 32'h00000000;
            end
        endcase
    end

    // sampled at the setup edge and held through the access phase
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prdata <= 32'h00000000;
        end else if (clkEn && setupPhase) begin
            prdata <= pwrite ? 32'h00000000 : readValue;
        end
    end

    // snapshot of what software sees, used to clear change flags
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            readSnap_r <= `UMS_RST_STATUS;
        end else if (clkEn && setupPhase) begin
            readSnap_r <= pwrite ? `UMS_RST_STATUS : statusWord;
        end
    end

    // ****************************************
    // modem control outputs
    // ****************************************
    // in loopback the pins are parked inactive so the far end
    // does not see the self test traffic
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            modemOut <= '1;
        end else if (clkEn) begin
            modemOut.requestToSendOutLow <=
                loopback | ~control_r[`UMS_CT_RTS_BIT];
            modemOut.dataTerminalReadyOutLow <=
                loopback | ~control_r[`UMS_CT_DTR_BIT];
            modemOut.userOutputOneLow <=
                loopback | ~control_r[`UMS_CT_USER_OUTPUT_ONE_BIT];
            modemOut.userOutputTwoLow <=
                loopback | ~control_r[`UMS_CT_USER_OUTPUT_TWO_BIT];
        end
    end

endmodule

// ---- ums_chk.sv ----
`include "ums_cfg.svh"
module ums_chk #(
    parameter int ADDR_W = 32
) (
    input wire logic                       clk,
    input wire logic                       reset_n,
    input wire logic                       clkEn,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [ADDR_W-1:0]          paddr,
    input wire logic [31:0]                pwdata,
    input wire logic [3:0]                 pstrb,
    input wire logic                       pready,
    input wire logic [31:0]                prdata,
    input wire logic                       pslverr,
    input wire ums_pkg::ums_modem_in_type  modemIn,
    input wire ums_pkg::ums_modem_out_type modemOut,
    input wire logic                       irq
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [ADDR_W-1:0] STAT = ADDR_W'(`UMS_ADDR_STATUS);
    localparam logic [ADDR_W-1:0] CTRL = ADDR_W'(`UMS_ADDR_CONTROL);
    // ****************************************
    // shadow of line sources and flags
    // ****************************************
    logic [4:0] ctl_r;
    logic [2:0] src, prev_r, ev, expF_r, capF_r;
    logic       stSetup, stRd, quiet;
    assign stSetup = psel && !penable && !pwrite && paddr == STAT;
    assign stRd = psel && penable && pready && !pwrite && paddr == STAT;
    assign src = ctl_r[4] ? ctl_r[3:1] : ~modemIn;
    assign quiet = src == prev_r;
    // prev starts deasserted: a carrier or clear-to-send line held through reset counts as a change
    assign ev = {src[2] ^ prev_r[2], prev_r[1] & ~src[1], src[0] ^ prev_r[0]};
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctl_r <= 5'h00;
        end else if (clkEn && psel && penable && pready && pwrite
                     && pstrb[0] && paddr == CTRL) begin
            ctl_r <= pwdata[4:0];
        end
    end
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prev_r <= 3'h0;
            expF_r <= 3'h0;
            capF_r <= 3'h0;
        end else if (clkEn) begin
            prev_r <= src;
            expF_r <= (stRd ? expF_r & ~capF_r : expF_r) | ev;
            capF_r <= stSetup ? expF_r : capF_r;
        end
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_quiet_read;
        (quiet && stSetup) ##1 (quiet && stRd);
    endsequence
    a_cd_live: assert property (
        stRd |-> prdata[7] == $past(src[2]))
        else $error("carrier bit off its source");
    a_ri_live: assert property (
        stRd |-> prdata[6] == $past(src[1]))
        else $error("ring bit off its source");
    a_cts_live: assert property (
        stRd |-> prdata[4] == $past(src[0]))
        else $error("clear to send bit off its source");
    a_cd_flag: assert property (
        stRd |-> prdata[3] == capF_r[2])
        else $error("carrier change flag wrong");
    a_ri_flag: assert property (
        stRd |-> prdata[2] == capF_r[1])
        else $error("ring trailing flag wrong");
    a_cts_flag: assert property (
        stRd |-> prdata[0] == capF_r[0])
        else $error("clear to send change flag wrong");
    a_read_clears: assert property (
        s_quiet_read ##1 s_quiet_read |-> prdata[3:2] == 2'b00 && !prdata[0])
        else $error("flag survived a read");
    a_rsvd_zero: assert property (
        stRd |-> prdata[31:8] == 24'h0 && !prdata[5] && !prdata[1])
        else $error("reserved bit set");
    a_stat_write: assert property (
        psel && !penable && pwrite && paddr == STAT |=> pready && !pslverr)
        else $error("status write not answered cleanly");
endmodule

// ---- ums_modem_peer.sv ----
module ums_modem_peer (
    input  wire logic                       clk,
    input  wire logic [2:0]                 lineReq,
    input  wire logic                       ctsFollowsRts,
    input  wire logic [2:0]                 lag,
    input  wire ums_pkg::ums_modem_out_type modemOut,
    output ums_pkg::ums_modem_in_type       modemIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] want, pins_r, wait_r;
    // no reset: a data set keeps its lines while our side resets
    initial begin
        pins_r = 3'h7;
        wait_r = 3'h0;
    end
    assign want = ctsFollowsRts ?
        {lineReq[2:1], !modemOut.requestToSendOutLow} : lineReq;
    assign modemIn = pins_r;
    always @(posedge clk) begin
        if (pins_r == ~want) begin
            wait_r <= 3'h0;
        end else if (wait_r >= lag) begin
            pins_r <= ~want;
            wait_r <= 3'h0;
        end else begin
            wait_r <= wait_r + 3'h1;
        end
    end
endmodule

// ---- tb_top.sv ----
`include "ums_cfg.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [31:0] data;
        logic        err;
    } ums_note_type;
    logic                       clk, reset_n, clkEn, psel, penable, pwrite;
    logic                       pready, pslverr, irq, follow;
    logic [31:0]                paddr, pwdata, prdata;
    logic [3:0]                 pstrb;
    logic [2:0]                 lineReq, lag, flags;
    logic [4:0]                 ctl;
    ums_pkg::ums_modem_in_type  modemIn;
    ums_pkg::ums_modem_out_type modemOut;
    ums_note_type               notes[$];
    ums_note_type               note;
    int                         n_fail, samples_checked, cycles;
    ums_modem_status i_dut (.clk(clk), .reset_n(reset_n), .clkEn(clkEn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .modemIn(modemIn), .modemOut(modemOut),
        .irq(irq));
    ums_modem_peer i_peer (.clk(clk), .lineReq(lineReq),
        .ctsFollowsRts(follow), .lag(lag), .modemOut(modemOut),
        .modemIn(modemIn));
    always #10 clk = ~clk;
    // ****************************************
    // checking
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_fail++;
            results();
        end
        if (pready === 1'b1) begin
            if (notes.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                note = notes.pop_front();
                check(prdata, note.data);
                check({31'h0, pslverr}, {31'h0, note.err});
            end
        end
    end
    // ****************************************
    // bus and line tasks
    // ****************************************
    function automatic logic [2:0] src();
        return ctl[4] ? ctl[3:1]
                      : {lineReq[2:1], follow ? ctl[1] : lineReq[0]};
    endfunction
    task automatic apb(input logic [31:0] a, input logic w,
                       input logic [31:0] d, input logic [31:0] e,
                       input logic er);
        int n;
        notes.push_back('{e, er});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) check(32'h0, 32'h1);
    endtask
    task automatic idle();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic xfer(input logic [31:0] a, input logic w,
                        input logic [31:0] d, input logic [31:0] e,
                        input logic er);
        apb(a, w, d, e, er);
        idle();
    endtask
    task automatic readStatus(input bit more);
        logic [2:0] s;
        s = src();
        apb(`UMS_ADDR_STATUS, 1'b0, 32'h0,
            {24'h0, s[2:1], 1'b0, s[0], flags[2:1], 1'b0, flags[0]}, 1'b0);
        flags = 3'h0;
        if (!more) idle();
    endtask
    // lines and control change together, then settle past the peer lag
    task automatic apply(input logic [2:0] v, input logic [4:0] c);
        logic [2:0] old, nw;
        old = src();
        lineReq <= v;
        xfer(`UMS_ADDR_CONTROL, 1'b1, {27'h0, c}, 32'h0, 1'b0);
        ctl = c;
        repeat (12) @(posedge clk);
        nw = src();
        flags |= {old[2] ^ nw[2], old[1] & ~nw[1], old[0] ^ nw[0]};
    endtask
    task automatic doReset(input int n);
        logic [2:0] s;
        reset_n <= 1'b0;
        repeat (n) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        ctl = 5'h00;
        s = src();
        flags = {s[2], 1'b0, s[0]};
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        clkEn = 1'b1;
        {psel, penable, pwrite, follow} = 4'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        lineReq = 3'h0;
        lag = 3'h0;
        ctl = 5'h00;
        flags = 3'h0;
        void'($urandom(32'h0030));
        doReset(8);
        readStatus(0);
        xfer(`UMS_ADDR_CONTROL, 1'b0, 32'h0, 32'h0, 1'b0);
        xfer(`UMS_ADDR_IRQ_MASK, 1'b0, 32'h0, 32'h0, 1'b0);
        xfer(32'h5000111c, 1'b0, 32'h0, 32'h0, 1'b1);
        xfer(32'h5000111c, 1'b1, 32'hff, 32'h0, 1'b1);
        pstrb <= 4'he;
        xfer(`UMS_ADDR_CONTROL, 1'b1, 32'h1f, 32'h0, 1'b0);
        pstrb <= 4'hf;
        xfer(`UMS_ADDR_CONTROL, 1'b0, 32'h0, 32'h0, 1'b0);
        $display("test reset values done");
        for (int i = 0; i < 16; i++) begin
            lag <= 3'($urandom % 8);
            apply(3'($urandom), 5'($urandom) & 5'h0f);
            readStatus(i % 2);
            if (i % 2 == 1) readStatus(0);
        end
        xfer(`UMS_ADDR_CONTROL, 1'b0, 32'h0, {27'h0, ctl}, 1'b0);
        check({28'h0, modemOut},
              {28'h0, ~ctl[1], ~ctl[0], ~ctl[2], ~ctl[3]});
        $display("test random lines done");
        apply(3'h0, 5'h00);
        readStatus(0);
        for (int i = 0; i < 8; i++) begin
            apply(3'h0, {1'b1, 3'(i), 1'b0});
            readStatus(0);
            check({28'h0, modemOut}, 32'hf);
        end
        apply(3'h7, ctl);
        readStatus(0);
        apply(3'h7, 5'h00);
        readStatus(0);
        $display("test loopback done");
        apply(3'h0, 5'h00);
        follow <= 1'b1;
        lag <= 3'h5;
        @(posedge clk);
        apply(3'h0, 5'h02);
        readStatus(0);
        apply(3'h0, 5'h00);
        readStatus(0);
        follow <= 1'b0;
        @(posedge clk);
        $display("test slow peer done");
        xfer(`UMS_ADDR_STATUS, 1'b1, 32'hffffffff, 32'h0, 1'b0);
        readStatus(0);
        apply(3'h7, 5'h00);
        readStatus(0);
        doReset(3);
        readStatus(1);
        readStatus(0);
        $display("test reset held lines done");
        xfer(`UMS_ADDR_IRQ_STAT, 1'b1, 32'h7, 32'h0, 1'b0);
        xfer(`UMS_ADDR_IRQ_MASK, 1'b1, 32'h7, 32'h0, 1'b0);
        check({31'h0, irq}, 32'h0);
        apply(3'h3, 5'h00);
        check({31'h0, irq}, 32'h1);
        xfer(`UMS_ADDR_IRQ_STAT, 1'b0, 32'h0, 32'h1, 1'b0);
        readStatus(0);
        xfer(`UMS_ADDR_IRQ_STAT, 1'b1, 32'h1, 32'h0, 1'b0);
        idle();
        check({31'h0, irq}, 32'h0);
        xfer(`UMS_ADDR_IRQ_MASK, 1'b1, 32'h0, 32'h0, 1'b0);
        apply(3'h7, 5'h00);
        check({31'h0, irq}, 32'h0);
        xfer(`UMS_ADDR_IRQ_STAT, 1'b0, 32'h0, 32'h1, 1'b0);
        $display("test interrupt done");
        results();
    end
endmodule
bind ums_modem_status ums_chk #(.ADDR_W(ADDR_W)) i_chk (.clk(clk),
    .reset_n(reset_n), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .modemIn(modemIn), .modemOut(modemOut), .irq(irq));
